//--- rtl/ppm_pkg.sv
// Package for the peripheral pin multiplexer: select bit positions and carriers
package ppm_pkg;
  // System configuration bit positions
  localparam int SCFG_HOST_BIT = 1;
  localparam int SCFG_CHB_BIT = 2;
  localparam int SCFG_PORTB_LO_BIT = 5;
  localparam int SCFG_PORTB_HI_BIT = 6;
  localparam int SCFG_PORTC_BIT = 7;
  // Interrupt edge/pin mux register bit positions
  localparam int IMUX_DAISY_BIT = 2;
  localparam int IMUX_MEMSTB_BIT = 3;
  // Reset values
  localparam logic [7:0] SCFG_RESET = 8'h00;
  localparam logic [7:0] IMUX_RESET = 8'h00;

  typedef enum logic [1:0] {
    PPM_GRP_CPU,
    PPM_GRP_CHB,
    PPM_GRP_HOST
  } ppm_grp_e;

  // One shared pin: output value and output enable
  typedef struct packed {
    logic o;
    logic oe;
  } ppm_drv_s;

  // Port register side: output value, direction (1 = output)
  typedef struct packed {
    logic [7:0] dout;
    logic [7:0] dir;
  } ppm_port_s;
endpackage

//--- rtl/ppm_pin_mux.sv
// Peripheral pin multiplexer: steers shared pins between cores and parallel ports
`timescale 1ns/10ps
`default_nettype none
module ppm_pin_mux
  import ppm_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  // Register writes from the core
  input wire logic cfg_we,
  input wire logic [7:0] cfg_wdata,
  input wire logic imux_we,
  input wire logic [7:0] imux_wdata,
  output logic [7:0] sys_config,
  output logic [7:0] irq_pin_mux,
  // Port registers (owned outside) and read-back
  input wire ppm_port_s port_a_reg,
  input wire ppm_port_s port_b_reg,
  input wire ppm_port_s port_c_reg,
  input wire logic port_c_we,
  output logic [7:0] port_a_pins,
  output logic [7:0] port_b_pins,
  output logic [7:0] port_c_pins,
  output logic [1:0] irq_capture_clr,
  // Core-side serial 0 / serial 1 / clocked serial
  input wire logic ser0_transmit,
  input wire logic ser0_req_to_send,
  output logic ser0_receive,
  output logic ser0_clear_to_send,
  output logic ser0_carrier_detect,
  input wire logic ser1_transmit,
  output logic ser1_receive,
  output logic csio_rx_or_ser1_cts,
  input wire logic csio_transmit,
  input wire logic csio_clock,
  input wire logic dma1_end_of_transfer,
  // Channel A
  input wire logic chan_a_wait_request,
  input wire logic chan_a_term_ready_request,
  input wire logic chan_a_req_to_send,
  output logic chan_a_sync,
  output logic chan_a_clear_to_send,
  output logic chan_a_carrier_detect,
  // Channel B three-pin group and host group
  input wire logic chan_b_req_to_send,
  input wire logic chan_b_term_ready_request,
  input wire logic chan_b_wait_request,
  input wire logic host_interrupt,
  input wire logic host_transmit_ready,
  input wire logic host_receive_ready,
  // Channel B / host shared pins (7 pins plus 8-bit data)
  input wire logic [6:0] chan_b_out,
  input wire logic [6:0] chan_b_oe,
  output logic [6:0] chan_b_in,
  input wire logic [6:0] host_ctl_out,
  input wire logic [6:0] host_ctl_oe,
  output logic [6:0] host_ctl_in,
  input wire logic [7:0] host_data_bus_out,
  input wire logic host_data_bus_oe,
  output logic [7:0] host_data_bus,
  // Bus strobes and daisy chain
  input wire logic memory_write_strobe,
  input wire logic memory_read_strobe,
  input wire logic memory_request,
  input wire logic aux_io_chip_select,
  input wire logic daisy_chain_enable_out,
  // Interrupt pins
  input wire logic ext_irq_one_pin,
  input wire logic ext_irq_two_pin,
  input wire logic [1:0] irq_edge_mode,
  // Pins: port B group, port C group, three-pin group, port A group, channel B group, singles
  input wire logic [7:0] pb_pin_i,
  output logic [7:0] pb_pin_o,
  output logic [7:0] pb_pin_oe,
  input wire logic [5:0] pc_pin_i,
  output logic [5:0] pc_pin_o,
  output logic [5:0] pc_pin_oe,
  input wire logic [2:0] grp_pin_i,
  output logic [2:0] grp_pin_o,
  output logic [2:0] grp_pin_oe,
  input wire logic [7:0] pa_pin_i,
  output logic [7:0] pa_pin_o,
  output logic [7:0] pa_pin_oe,
  input wire logic [6:0] chb_pin_i,
  output logic [6:0] chb_pin_o,
  output logic [6:0] chb_pin_oe,
  output logic daisy_pin,
  output logic rdreq_pin
);
  logic [7:0] cfg_r, cfg_nxt, imux_r, imux_nxt;
  logic [7:0] pb_s1_r, pb_s2_r;
  logic [5:0] pc_s1_r, pc_s2_r;
  logic [2:0] grp_s1_r, grp_s2_r;
  logic [7:0] pa_s1_r, pa_s2_r;
  logic [6:0] chb_s1_r, chb_s2_r;
  logic [1:0] irq_s1_r, irq_s2_r;
  logic [1:0] clr_r, clr_nxt;
  logic pb_lo, pb_hi, pc_sel, host_mode, stb_sel;
  ppm_grp_e grp;

  // Select registers
  // Writes take effect one edge later; pins follow combinationally
  always_comb begin
    cfg_nxt = cfg_r;
    imux_nxt = imux_r;
    if (cfg_we) begin
      cfg_nxt = cfg_wdata;
    end
    if (imux_we) begin
      imux_nxt = imux_wdata;
    end
    // Capture-latch clear pulse on a one written to C7/C6 in edge mode
    clr_nxt = 2'b00;
    if (port_c_we) begin
      clr_nxt = port_c_reg.dout[7:6] & irq_edge_mode;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cfg_r <= SCFG_RESET;
      imux_r <= IMUX_RESET;
      clr_r <= 2'b00;
    end else begin
      cfg_r <= cfg_nxt;
      imux_r <= imux_nxt;
      clr_r <= clr_nxt;
    end
  end

  // Pin synchronisers; first stage feeds only the second
  // Irq stages reset high to match the idle level of those pins
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pb_s1_r <= 8'h00;
      pb_s2_r <= 8'h00;
      pc_s1_r <= 6'h00;
      pc_s2_r <= 6'h00;
      grp_s1_r <= 3'h0;
      grp_s2_r <= 3'h0;
      pa_s1_r <= 8'h00;
      pa_s2_r <= 8'h00;
      chb_s1_r <= 7'h00;
      chb_s2_r <= 7'h00;
      irq_s1_r <= 2'b11;
      irq_s2_r <= 2'b11;
    end else begin
      pb_s1_r <= pb_pin_i;
      pb_s2_r <= pb_s1_r;
      pc_s1_r <= pc_pin_i;
      pc_s2_r <= pc_s1_r;
      grp_s1_r <= grp_pin_i;
      grp_s2_r <= grp_s1_r;
      pa_s1_r <= pa_pin_i;
      pa_s2_r <= pa_s1_r;
      chb_s1_r <= chb_pin_i;
      chb_s2_r <= chb_s1_r;
      irq_s1_r <= {ext_irq_two_pin, ext_irq_one_pin};
      irq_s2_r <= irq_s1_r;
    end
  end

  assign sys_config = cfg_r;
  assign irq_pin_mux = imux_r;
  assign irq_capture_clr = clr_r;
  assign pb_lo = cfg_r[SCFG_PORTB_LO_BIT];
  assign pb_hi = cfg_r[SCFG_PORTB_HI_BIT];
  assign pc_sel = cfg_r[SCFG_PORTC_BIT];
  assign host_mode = cfg_r[SCFG_HOST_BIT];
  assign stb_sel = imux_r[IMUX_MEMSTB_BIT];

  // Three-pin group decode; bit 1 alone keeps the processor group
  always_comb begin
    case ({cfg_r[SCFG_HOST_BIT], cfg_r[SCFG_CHB_BIT]})
      2'b01: grp = PPM_GRP_CHB;
      2'b11: grp = PPM_GRP_HOST;
      default: grp = PPM_GRP_CPU;
    endcase
  end

  // Port B pins: 0 rts, 1 cts, 2 dcd, 3 tx0, 4 rx0, 5 tx1, 6 rx1, 7 csio rx
  always_comb begin
    pb_pin_o = 8'h00;
    pb_pin_oe = 8'h00;
    if (pb_lo) begin
      pb_pin_o[4:0] = port_b_reg.dout[4:0];
      pb_pin_oe[4:0] = port_b_reg.dir[4:0];
    end else begin
      pb_pin_o[0] = ser0_req_to_send;
      pb_pin_oe[0] = 1'b1;
      pb_pin_o[3] = ser0_transmit;
      pb_pin_oe[3] = 1'b1;
    end
    if (pb_hi) begin
      pb_pin_o[7:5] = port_b_reg.dout[7:5];
      pb_pin_oe[7:5] = port_b_reg.dir[7:5];
    end else begin
      pb_pin_o[5] = ser1_transmit;
      pb_pin_oe[5] = 1'b1;
    end
  end
  assign port_b_pins = pb_s2_r;
  // Port mode feeds fixed defaults back to the serial units: cts and dcd low, receive and csio rx high
  assign ser0_clear_to_send = pb_lo ? 1'b0 : pb_s2_r[1];
  assign ser0_carrier_detect = pb_lo ? 1'b0 : pb_s2_r[2];
  assign ser0_receive = pb_lo ? 1'b1 : pb_s2_r[4];
  assign ser1_receive = pb_hi ? 1'b1 : pb_s2_r[6];
  assign csio_rx_or_ser1_cts = pb_hi ? 1'b1 : pb_s2_r[7];

  // Port C pins: 0 dcd, 1 cts, 2 strobe/rts, 3 dtr/req, 4 sync, 5 wait/req
  always_comb begin
    pc_pin_o = 6'h00;
    pc_pin_oe = 6'h00;
    if (pc_sel) begin
      pc_pin_o[5:3] = port_c_reg.dout[5:3];
      pc_pin_oe[5:3] = port_c_reg.dir[5:3];
      pc_pin_o[1:0] = port_c_reg.dout[1:0];
      pc_pin_oe[1:0] = port_c_reg.dir[1:0];
    end else begin
      pc_pin_o[5] = chan_a_wait_request;
      pc_pin_oe[5] = 1'b1;
      pc_pin_o[3] = chan_a_term_ready_request;
      pc_pin_oe[3] = 1'b1;
    end
    // C2 strobe choice overrides the port select
    if (!stb_sel) begin
      pc_pin_o[2] = memory_write_strobe;
      pc_pin_oe[2] = 1'b1;
    end else if (pc_sel) begin
      pc_pin_o[2] = port_c_reg.dout[2];
      pc_pin_oe[2] = port_c_reg.dir[2];
    end else begin
      pc_pin_o[2] = chan_a_req_to_send;
      pc_pin_oe[2] = 1'b1;
    end
  end
  // C7/C6 have no output path at all
  assign port_c_pins = {irq_s2_r[1], irq_s2_r[0], pc_s2_r};
  assign chan_a_sync = pc_sel ? 1'b1 : pc_s2_r[4];
  assign chan_a_clear_to_send = pc_sel ? 1'b1 : pc_s2_r[1];
  assign chan_a_carrier_detect = pc_sel ? 1'b1 : pc_s2_r[0];

  // Three-pin group: 0 dma1_end_of_transfer/chan_b_req_to_send/rxrdy, 1 txs/dtrb/host_interrupt, 2 cks/wreqb/txrdy
  always_comb begin
    grp_pin_oe = 3'b111;
    case (grp)
      PPM_GRP_CHB: grp_pin_o = {chan_b_wait_request, chan_b_term_ready_request, chan_b_req_to_send};
      PPM_GRP_HOST: grp_pin_o = {host_transmit_ready, host_interrupt, host_receive_ready};
      PPM_GRP_CPU: grp_pin_o = {csio_clock, csio_transmit, dma1_end_of_transfer};
      default: grp_pin_o = {csio_clock, csio_transmit, dma1_end_of_transfer};
    endcase
  end

  // Port A / host data and channel B / host control share pins
  always_comb begin
    if (host_mode) begin
      pa_pin_o = host_data_bus_out;
      pa_pin_oe = {8{host_data_bus_oe}};
      chb_pin_o = host_ctl_out;
      chb_pin_oe = host_ctl_oe;
    end else begin
      pa_pin_o = port_a_reg.dout;
      pa_pin_oe = port_a_reg.dir;
      chb_pin_o = chan_b_out;
      chb_pin_oe = chan_b_oe;
    end
  end
  assign port_a_pins = pa_s2_r;
  // Host data reads back through the port A stages
  assign host_data_bus = pa_s2_r;
  // Inactive side sees idle-high inputs
  assign chan_b_in = host_mode ? 7'h7f : chb_s2_r;
  assign host_ctl_in = host_mode ? chb_s2_r : 7'h7f;

  // Daisy and strobe pins, output only; a zero select keeps the first function
  always_comb begin
    daisy_pin = aux_io_chip_select;
    if (imux_r[IMUX_DAISY_BIT]) begin
      daisy_pin = daisy_chain_enable_out;
    end
    rdreq_pin = memory_read_strobe;
    if (stb_sel) begin
      rdreq_pin = memory_request;
    end
  end
endmodule
`default_nettype wire

//--- tb/ppm_pad_model.sv
// Far-side pads: shared pin level from mux drive and the outside party
`timescale 1ns/10ps
`default_nettype none
module ppm_pad_model #(parameter int W = 8) (
  input wire logic [W-1:0] o,
  input wire logic [W-1:0] oe,
  input wire logic [W-1:0] ext,
  output logic [W-1:0] i
);
  // Released pin shows the outside level, never the last driven value
  assign i = (o & oe) | (ext & ~oe);
endmodule
`default_nettype wire

//--- tb/ppm_pin_mux_asserts.sv
// Checker: shared-pin selections and capture clear of the pin mux
`timescale 1ns/10ps
`default_nettype none
module ppm_pin_mux_asserts
  import ppm_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic port_c_we,
  input wire logic ser0_clear_to_send,
  input wire logic chan_a_req_to_send,
  input wire logic memory_write_strobe,
  input wire logic memory_read_strobe,
  input wire logic memory_request,
  input wire logic aux_io_chip_select,
  input wire logic daisy_chain_enable_out,
  input wire logic ext_irq_one_pin,
  input wire logic ext_irq_two_pin,
  input wire logic daisy_pin,
  input wire logic rdreq_pin,
  input wire logic [7:0] sys_config,
  input wire logic [7:0] irq_pin_mux,
  input wire logic [7:0] port_c_pins,
  input wire logic [7:0] pb_pin_o,
  input wire logic [7:0] pb_pin_oe,
  input wire logic [5:0] pc_pin_o,
  input wire logic [5:0] pc_pin_oe,
  input wire logic [1:0] irq_capture_clr,
  input wire logic [1:0] irq_edge_mode,
  input wire ppm_port_s port_b_reg,
  input wire ppm_port_s port_c_reg
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // Two sync flops, so the pin must hold three edges
  sequence s_irq_steady;
    $stable({ext_irq_two_pin, ext_irq_one_pin})[*3];
  endsequence
  chk_pb_low: assert property (sys_config[5] |->
    pb_pin_o[4:0] == port_b_reg.dout[4:0] && pb_pin_oe[4:0] == port_b_reg.dir[4:0]) else $error("pb low");
  chk_pc_port: assert property (sys_config[7] |->
    {pc_pin_o[5:3], pc_pin_o[1:0]} == {port_c_reg.dout[5:3], port_c_reg.dout[1:0]}) else $error("pc port");
  chk_cts_low: assert property (sys_config[5] |-> !ser0_clear_to_send) else $error("ser0_clear_to_send");
  chk_wr_strobe: assert property (!irq_pin_mux[3] |->
    pc_pin_oe[2] && pc_pin_o[2] == memory_write_strobe) else $error("wr strobe");
  chk_rts_pick: assert property (irq_pin_mux[3] |->
    pc_pin_o[2] == (sys_config[7] ? port_c_reg.dout[2] : chan_a_req_to_send)) else $error("rts pick");
  chk_daisy_pick: assert property (daisy_pin ==
    (irq_pin_mux[2] ? daisy_chain_enable_out : aux_io_chip_select)) else $error("daisy");
  chk_rd_pick: assert property (rdreq_pin ==
    (irq_pin_mux[3] ? memory_request : memory_read_strobe)) else $error("rd pick");
  chk_irq_read: assert property (s_irq_steady |->
    port_c_pins[7:6] == {ext_irq_two_pin, ext_irq_one_pin}) else $error("irq read");
  chk_clr_pulse: assert property (port_c_we |=>
    irq_capture_clr == $past(port_c_reg.dout[7:6] & irq_edge_mode)) else $error("clr");
  chk_clr_idle: assert property (!port_c_we |=> irq_capture_clr == 2'b00) else $error("clr idle");
  chk_pb_high: assert property (sys_config[6] |->
    pb_pin_o[7:5] == port_b_reg.dout[7:5] && pb_pin_oe[7:5] == port_b_reg.dir[7:5]) else $error("pb high");
endmodule
bind ppm_pin_mux ppm_pin_mux_asserts i_chk (.*);
`default_nettype wire

//--- tb/ppm_pin_mux_tb.sv
// Bench: random mux settings against a behavioural pin model
`timescale 1ns/10ps
`default_nettype none
module ppm_pin_mux_tb;
  import ppm_pkg::*;
  logic clk = 0, reset_n = 0, we = 0, pcwe = 0, s0cts, dsy, rdq;
  logic [7:0] cfg = 8'h00, imux = 8'h00, sc, im, pbo, pboe, pbp, pcp, pao, paoe, pbi, pai, eo, eoe, pm;
  logic [5:0] pco, pcoe, pci;
  logic [2:0] gro, groe, gri;
  logic [6:0] cbo, cboe, cbi;
  logic [1:0] clr;
  logic s0rx, s0dcd, s1rx, csrx, casy, cacts, cadcd;
  logic [7:0] pap, hdb;
  logic [6:0] cbin, hcin;
  logic [159:0] r = '0;
  integer seed = 32'h21e0, failures = 0, check_count = 0, cyc = 0, k;
  always #5 clk = ~clk;
  ppm_pin_mux i_dut (.clk, .reset_n, .cfg_we(we), .cfg_wdata(cfg), .imux_we(we), .imux_wdata(imux),
    .sys_config(sc), .irq_pin_mux(im), .port_a_reg(r[15:0]), .port_b_reg(r[31:16]), .port_c_reg(r[47:32]),
    .port_c_we(pcwe), .port_a_pins(pap), .port_b_pins(pbp), .port_c_pins(pcp), .irq_capture_clr(clr),
    .ser0_transmit(r[48]), .ser0_req_to_send(r[49]), .ser0_receive(s0rx), .ser0_clear_to_send(s0cts),
    .ser0_carrier_detect(s0dcd), .ser1_transmit(r[50]), .ser1_receive(s1rx), .csio_rx_or_ser1_cts(csrx),
    .csio_transmit(r[51]), .csio_clock(r[52]), .dma1_end_of_transfer(r[53]), .chan_a_wait_request(r[54]),
    .chan_a_term_ready_request(r[55]), .chan_a_req_to_send(r[56]), .chan_a_sync(casy),
    .chan_a_clear_to_send(cacts), .chan_a_carrier_detect(cadcd), .chan_b_req_to_send(r[57]),
    .chan_b_term_ready_request(r[58]), .chan_b_wait_request(r[59]), .host_interrupt(r[60]),
    .host_transmit_ready(r[61]), .host_receive_ready(r[62]), .chan_b_out(r[69:63]), .chan_b_oe(r[76:70]),
    .chan_b_in(cbin), .host_ctl_out(r[83:77]), .host_ctl_oe(r[90:84]), .host_ctl_in(hcin),
    .host_data_bus_out(r[98:91]), .host_data_bus_oe(r[99]), .host_data_bus(hdb),
    .memory_write_strobe(r[100]), .memory_read_strobe(r[101]),
    .memory_request(r[102]), .aux_io_chip_select(r[103]), .daisy_chain_enable_out(r[104]),
    .ext_irq_one_pin(r[105]), .ext_irq_two_pin(r[106]), .irq_edge_mode(r[108:107]), .pb_pin_i(pbi),
    .pb_pin_o(pbo), .pb_pin_oe(pboe), .pc_pin_i(pci), .pc_pin_o(pco), .pc_pin_oe(pcoe), .grp_pin_i(gri),
    .grp_pin_o(gro), .grp_pin_oe(groe), .pa_pin_i(pai), .pa_pin_o(pao), .pa_pin_oe(paoe), .chb_pin_i(cbi),
    .chb_pin_o(cbo), .chb_pin_oe(cboe), .daisy_pin(dsy), .rdreq_pin(rdq));
  ppm_pad_model #(8) i_pb (.o(pbo), .oe(pboe), .ext(r[116:109]), .i(pbi));
  ppm_pad_model #(6) i_pc (.o(pco), .oe(pcoe), .ext(r[122:117]), .i(pci));
  ppm_pad_model #(3) i_gr (.o(gro), .oe(groe), .ext(r[125:123]), .i(gri));
  ppm_pad_model #(8) i_pa (.o(pao), .oe(paoe), .ext(r[133:126]), .i(pai));
  ppm_pad_model #(7) i_cb (.o(cbo), .oe(cboe), .ext(r[140:134]), .i(cbi));
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    check_count++;
    if (s !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task results;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task check_pins;
    pm = {cfg[6] ? 3'h7 : 3'h0, cfg[5] ? 5'h1f : 5'h00};
    eo = r[31:24] & pm | {2'b0, r[50], 1'b0, r[48], 2'b0, r[49]} & ~pm;
    eoe = r[23:16] & pm | 8'h29 & ~pm;
    chk("cfg", sc, cfg);
    chk("pb oe", pboe, eoe);
    chk("pb out", pbo & eoe, eo & eoe);
    chk("pb read", pbp, eo & eoe | r[116:109] & ~eoe);
    chk("ser0_clear_to_send", s0cts, cfg[5] ? 1'b0 : r[110]);
    chk("rx0", s0rx, cfg[5] ? 1'b1 : r[113]);
    chk("ser0_carrier_detect", s0dcd, cfg[5] ? 1'b0 : r[111]);
    chk("rx1", s1rx, cfg[6] ? 1'b1 : r[115]);
    chk("csio rx", csrx, cfg[6] ? 1'b1 : r[116]);
    pm = cfg[7] ? 8'h3b : 8'h00;
    eo = r[47:40] & pm | {2'b0, r[54], 1'b0, r[55], 3'b0} & ~pm;
    eoe = r[39:32] & pm | 8'h28 & ~pm;
    if (!imux[3]) {eo[2], eoe[2]} = {r[100], 1'b1};
    else if (cfg[7]) {eo[2], eoe[2]} = {r[42], r[34]};
    else {eo[2], eoe[2]} = {r[56], 1'b1};
    chk("pc oe", pcoe, eoe[5:0]);
    chk("pc out", pco & eoe[5:0], eo[5:0] & eoe[5:0]);
    chk("pc irq", pcp[7:6], r[106:105]);
    chk("pc read", pcp[5:0], eo[5:0] & eoe[5:0] | r[122:117] & ~eoe[5:0]);
    chk("a sync", casy, cfg[7] ? 1'b1 : r[121]);
    chk("a cts", cacts, cfg[7] ? 1'b1 : r[118]);
    chk("a dcd", cadcd, cfg[7] ? 1'b1 : r[117]);
    case (cfg[2:1])
      2'b10: eo = r[59:57];
      2'b11: eo = {r[61], r[60], r[62]};
      default: eo = {r[52], r[51], r[53]};
    endcase
    chk("grp", gro, eo);
    chk("grp oe", groe, 8'h07);
    chk("pa", pao & paoe, cfg[1] ? r[98:91] & {8{r[99]}} : r[15:8] & r[7:0]);
    chk("chb", cbo & cboe, cfg[1] ? r[83:77] & r[90:84] : r[69:63] & r[76:70]);
    eo = cfg[1] ? r[98:91] : r[15:8];
    eoe = cfg[1] ? {8{r[99]}} : r[7:0];
    chk("pa oe", paoe, eoe);
    chk("pa read", pap, eo & eoe | r[133:126] & ~eoe);
    chk("host data", hdb, eo & eoe | r[133:126] & ~eoe);
    eo = cfg[1] ? r[83:77] : r[69:63];
    eoe = cfg[1] ? r[90:84] : r[76:70];
    pm = eo & eoe | r[140:134] & ~eoe;
    chk("chb oe", cboe, eoe);
    chk("chb in", cbin, cfg[1] ? 8'h7f : pm);
    chk("host ctl in", hcin, cfg[1] ? pm : 8'h7f);
    chk("daisy", dsy, imux[2] ? r[104] : r[103]);
    chk("rdreq", rdq, imux[3] ? r[102] : r[101]);
    chk("imux", im, imux);
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      failures++;
      results();
    end
  end
  initial begin
    @(negedge clk);
    r = {$random(seed), $random(seed), $random(seed), $random(seed), $random(seed)};
    repeat (4) @(negedge clk);
    reset_n = 1;
    @(negedge clk);
    chk("cfg reset", sc, 8'h00);
    chk("imux reset", im, 8'h00);
    chk("daisy reset", dsy, r[103]);
    repeat (2) @(negedge clk);
    check_pins();
    for (k = 0; k < 200; k++) begin
      r = {$random(seed), $random(seed), $random(seed), $random(seed), $random(seed)};
      cfg = 8'($random(seed));
      imux = 8'($random(seed));
      we = 1;
      @(negedge clk);
      we = 0;
      repeat (3) @(negedge clk);
      check_pins();
    end
    // Mid-run reset must throw away a random setting
    reset_n = 0;
    repeat (3) @(negedge clk);
    reset_n = 1;
    cfg = 8'h00;
    imux = 8'h00;
    repeat (3) @(negedge clk);
    check_pins();
    for (k = 0; k < 16; k++) begin
      r = {$random(seed), $random(seed), $random(seed), $random(seed), $random(seed)};
      pcwe = 1;
      @(negedge clk);
      pcwe = 0;
      chk("clr", clr, r[47:46] & r[108:107]);
      @(negedge clk);
      chk("clr idle", clr, 8'h00);
    end
    results();
  end
endmodule
`default_nettype wire
